/* dimmer_cfg.svh */
// Timing counts, code values and pump settings for the pulse-count LED dimmer.
// Assumes a single 20 MHz clock shared by the host end and the device end.
`ifndef DIMMER_CFG_SVH
`define DIMMER_CFG_SVH

// Clock rate in kHz.
`define CLK_KHZ            20000
// Shutdown low time in microseconds, and its least count of cycles.
`define OFF_TIME_US        1500
`define OFF_CYCLES         ((`OFF_TIME_US * `CLK_KHZ + 999) / 1000)
// Pump mode switch delay in microseconds, and its count.
`define PUMP_DELAY_US      400
`define PUMP_CYCLES        ((`PUMP_DELAY_US * `CLK_KHZ) / 1000)
// Host setup time in microseconds, and its count.
`define SETUP_TIME_US      10
`define SETUP_CYCLES       ((`SETUP_TIME_US * `CLK_KHZ + 999) / 1000)
// Host pulse low and high time in nanoseconds; 300 ns, held at 1 us for margin.
`define PULSE_TIME_NS      1000
`define PULSE_CYCLES       ((`PULSE_TIME_NS * `CLK_KHZ / 1000 + 999) / 1000)
// Current codes: 31 is full scale (150 mA), 0 is zero current.
`define CODE_FULL          5'h1f
`define CODE_ZERO          5'h00

`endif

/* dimmer_device.sv */
// Device end: pulse counting, shutdown timing, pump mode and protection gating.
// Assumes uv_low, over_temp and reg_fail come from analog comparators (async).
`timescale 1ns/10ps
`include "dimmer_cfg.svh"
module dimmer_device #(
   parameter int unsigned OFF_COUNT  = `OFF_CYCLES,
   parameter int unsigned PUMP_COUNT = `PUMP_CYCLES
) (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   dimmer_link_if.device_end      link,
   input  wire logic              uv_low,
   input  wire logic              over_temp,
   input  wire logic              reg_fail,
   output dimmer_pkg::code_type   led_channel_a_sink,
   output dimmer_pkg::code_type   led_channel_b_sink,
   output logic                   sink_oe_n,
   output dimmer_pkg::pump_mode_type pump_output,
   output logic                   enabled
);
   import dimmer_pkg::*;

   // Synchroniser stage one; nothing but stage two reads it.
   logic [3:0]    meta_r;
   logic [3:0]    meta_nxt;     // Raw inputs, packed in a fixed order.
   // Synchroniser stage two: bit 0 line, 1 undervoltage, 2 over-temperature, 3 regulation.
   logic [3:0]    sync_r;
   logic [3:0]    sync_nxt;     // Stage one, moved along.
   // Previous synchronised line level, kept for falling-edge detection.
   logic          line_d_r;
   logic          line_d_nxt;   // Synchronised line, delayed one cycle.

   // Sequencer state: shutdown, enabled at zero current, or dimming.
   dev_state_type state_r;
   dev_state_type state_nxt;    // Next sequencer state.
   // Current code; it doubles as the pulse counter, so no second count is kept.
   code_type      code_r;
   code_type      code_nxt;     // Next current code.
   // Charge-pump mode held by the sequencer.
   pump_mode_type mode_r;
   pump_mode_type mode_nxt;     // Next pump mode.

   // Next values of the registered outputs.
   code_type      drive_nxt;    // Code for both channels.
   logic          oe_n_nxt;     // High while the channels float.
   pump_mode_type pump_nxt;     // Pump mode shown outside.
   logic          enabled_nxt;  // Device out of shutdown.
   logic          live;         // Channels may carry current.

   // Decoded and synchronised signals.
   logic          line_s;       // Synchronised enable/dim line.
   logic          uv_s;         // Synchronised undervoltage flag.
   logic          ot_s;         // Synchronised over-temperature flag.
   logic          rf_s;         // Synchronised regulation-failure flag.
   logic          fall;         // Line went from high to low.
   logic          off_run;      // Shutdown timer counts.
   logic          off_done;     // Line low for the whole shutdown time.
   logic          pump_run;     // Pump delay timer counts.
   logic          pump_done;    // Regulation failed for the whole pump delay.

   // True in every state but shutdown; the timers, pump and outputs all ask it.
   function automatic logic is_on(input dev_state_type s);
      is_on = (s != DEV_SHUTDOWN);
   endfunction : is_on

   // Step the code down one; zero wraps to full scale.
   function automatic code_type step_down(input code_type c);
      step_down = (c == `CODE_ZERO) ? `CODE_FULL : c - 5'h01;
   endfunction : step_down

   // Name the synchronised bits.
   assign line_s = sync_r[0];
   assign uv_s   = sync_r[1];
   assign ot_s   = sync_r[2];
   assign rf_s   = sync_r[3];

   // The delayed copy resets low like the idle line, so reset makes no false edge.
   assign fall = line_d_r && !line_s;

   // low time counted
   // Any high level on the line restarts the count, so short pulses never shut down.
   assign off_run = is_on(state_r) && !line_s;

   // delay only in 1x
   // A regulation dropout shorter than the delay leaves the pump in 1x.
   assign pump_run = is_on(state_r) && rf_s && (mode_r == PUMP_1X);

   dimmer_timer #(.COUNT(OFF_COUNT)) off_timer (
      .clock   (clock),
      .sys_rst (sys_rst),
      .run     (off_run),
      .done    (off_done)
   );

   dimmer_timer #(.COUNT(PUMP_COUNT)) pump_timer (
      .clock   (clock),
      .sys_rst (sys_rst),
      .run     (pump_run),
      .done    (pump_done)
   );

   // Synchroniser next values; every asynchronous input passes two flops before use.
   always_comb begin
      meta_nxt   = {reg_fail, over_temp, uv_low, link.enable_dim_line};
      sync_nxt   = meta_r;
      line_d_nxt = line_s;
   end

   // Register the synchroniser.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         // Idle levels: line low, flags clear.
         meta_r   <= 4'h0;
         sync_r   <= 4'h0;
         line_d_r <= 1'b0;
      end else begin
         meta_r   <= meta_nxt;
         sync_r   <= sync_nxt;
         line_d_r <= line_d_nxt;
      end
   end

   // Sequence states; the pulse count lives in the code register.
   always_comb begin
      state_nxt = state_r;
      code_nxt  = code_r;
      mode_nxt  = mode_r;
      case (state_r)
         DEV_SHUTDOWN: begin
            code_nxt = `CODE_ZERO;
            mode_nxt = PUMP_1X;
            if (line_s) begin
               state_nxt = DEV_ENABLED;
            end
         end
         DEV_ENABLED: begin
            // Waiting for the first falling edge; the current stays at zero.
            if (off_done) begin
               // Enabled but never pulsed, then held low: shut down again.
               state_nxt = DEV_SHUTDOWN;
            end else if (fall) begin
               code_nxt  = `CODE_FULL;
               state_nxt = DEV_DIMMING;
            end
         end
         DEV_DIMMING: begin
            // Each falling edge is one step; the shutdown edge steps too, which is harmless.
            if (off_done) begin
               // Long low time ends dimming.
               state_nxt = DEV_SHUTDOWN;
            end else if (fall) begin
               code_nxt = step_down(code_r);
            end
         end
         default: begin
            // An illegal code falls back to the safest state.
            state_nxt = DEV_SHUTDOWN;
         end
      endcase
      // 1x then 1.5x
      // The mode only rises while the device stays on, so shutdown always leaves 1x.
      if (pump_done && is_on(state_nxt)) begin
         mode_nxt = PUMP_1P5;
      end
   end

   // Register the sequencer.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         // Power-up: shut down, zero current, 1x.
         state_r <= DEV_SHUTDOWN;
         code_r  <= `CODE_ZERO;
         mode_r  <= PUMP_1X;
      end else begin
         state_r <= state_nxt;
         code_r  <= code_nxt;
         mode_r  <= mode_nxt;
      end
   end

   // Output next values; they look at the next state so outputs and state switch together.
   always_comb begin
      // protection gating
      // The count survives protection; only the drive is forced to zero.
      live        = is_on(state_nxt) && !uv_s && !ot_s;
      drive_nxt   = live ? code_nxt : `CODE_ZERO;
      oe_n_nxt    = !is_on(state_nxt);
      pump_nxt    = mode_nxt;
      enabled_nxt = is_on(state_nxt);
   end

   // Register the outputs; every top-level output comes straight from a flip-flop.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         // Shut down with the channels floating.
         led_channel_a_sink <= `CODE_ZERO;
         led_channel_b_sink <= `CODE_ZERO;
         sink_oe_n          <= 1'b1;
         pump_output        <= PUMP_1X;
         enabled            <= 1'b0;
      end else begin
         // Both channels carry the same code; matching is left to the analog side.
         led_channel_a_sink <= drive_nxt;
         led_channel_b_sink <= drive_nxt;
         sink_oe_n          <= oe_n_nxt;
         pump_output        <= pump_nxt;
         enabled            <= enabled_nxt;
      end
   end
endmodule : dimmer_device

/* dimmer_host.sv */
// Host end: turns a requested pulse count into a legal pulse train.
// Assumes the device end samples the line through its own synchroniser.
`timescale 1ns/10ps
`include "dimmer_cfg.svh"
module dimmer_host (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic              start,
   input  wire logic [5:0]        pulses,
   input  wire logic              shutdown,
   output logic                   busy,
   dimmer_link_if.host_end        link
);
   import dimmer_pkg::*;

   dimmer_pkg::host_state_type state_r, state_nxt;  // Host sequence.
   logic [15:0] cnt_r, cnt_nxt;                     // Phase timer.
   logic [5:0]  left_r, left_nxt;                   // Pulses still owed.
   logic        line_r, line_nxt;                   // Line level.
   logic        busy_nxt;

   // One pulse is low then high; the setup wait runs once after leaving shutdown.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
      left_nxt  = left_r;
      line_nxt  = line_r;
      case (state_r)
         HOST_IDLE: begin
            if (shutdown) begin
               line_nxt = 1'b0;
            end else if (start && pulses != 6'h00) begin
               left_nxt = pulses;
               if (!line_r) begin
                  line_nxt  = 1'b1;
                  cnt_nxt   = 16'(`SETUP_CYCLES);
                  state_nxt = HOST_SETUP;
               end else begin
                  line_nxt  = 1'b0;
                  cnt_nxt   = 16'(`PULSE_CYCLES);
                  state_nxt = HOST_LOW;
               end
            end
         end
         HOST_SETUP: begin
            if (cnt_r == 16'h0000) begin
               line_nxt  = 1'b0;
               cnt_nxt   = 16'(`PULSE_CYCLES);
               state_nxt = HOST_LOW;
            end
         end
         HOST_LOW: begin
            if (cnt_r == 16'h0000) begin
               line_nxt  = 1'b1;
               left_nxt  = left_r - 6'h01;
               cnt_nxt   = 16'(`PULSE_CYCLES);
               state_nxt = HOST_HIGH;
            end
         end
         HOST_HIGH: begin
            if (cnt_r == 16'h0000) begin
               if (left_r == 6'h00) begin
                  state_nxt = HOST_IDLE;
               end else begin
                  line_nxt  = 1'b0;
                  cnt_nxt   = 16'(`PULSE_CYCLES);
                  state_nxt = HOST_LOW;
               end
            end
         end
         default: begin
            state_nxt = HOST_IDLE;
         end
      endcase
      busy_nxt = (state_nxt != HOST_IDLE);
   end

   // Register host state.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= HOST_IDLE;
         cnt_r   <= 16'h0000;
         left_r  <= 6'h00;
         line_r  <= 1'b0;
         busy    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         left_r  <= left_nxt;
         line_r  <= line_nxt;
         busy    <= busy_nxt;
      end
   end

   assign link.enable_dim_line = line_r;
endmodule : dimmer_host

/* dimmer_link_if.sv */
// The single enable/dim wire between host and device.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface dimmer_link_if;
   // Level on the enable/dim line, driven by the host.
   logic enable_dim_line;

   modport host_end (output enable_dim_line);
   modport device_end (input enable_dim_line);
endinterface : dimmer_link_if

/* dimmer_monitor.sv */
// Checker on the dimming link and the device outputs.
// Assumes one clock; fed from the signals that join both ends.
`timescale 1ns/10ps
module dimmer_monitor #(
   parameter int unsigned OFF_COUNT  = 50,
   parameter int unsigned PUMP_COUNT = 20
) (
   input wire logic                      clock,
   input wire logic                      sys_rst,
   input wire logic                      enable_dim_line,
   input wire logic                      uv_low,
   input wire logic                      over_temp,
   input wire logic                      reg_fail,
   input wire dimmer_pkg::code_type      led_channel_a_sink,
   input wire dimmer_pkg::code_type      led_channel_b_sink,
   input wire logic                      sink_oe_n,
   input wire dimmer_pkg::pump_mode_type pump_output,
   input wire logic                      enabled
);
   import dimmer_pkg::*;
   wire code_type code_a = led_channel_a_sink; // Short alias.
   int unsigned   low_cnt_r;                   // Cycles the line has stayed low.
   int unsigned   fail_cnt_r;                  // Cycles of failed regulation while on.
   logic [3:0]    calm_r;                      // Cycles since protection let go.

   // Counters; calm_r masks the few cycles where protection settles.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         low_cnt_r  <= 0;
         fail_cnt_r <= 0;
         calm_r     <= 4'h0;
      end else begin
         low_cnt_r  <= enable_dim_line ? 0 : low_cnt_r + 1;
         fail_cnt_r <= (reg_fail && enabled) ? fail_cnt_r + 1 : 0;
         calm_r     <= (uv_low || over_temp) ? 4'h0 : calm_r + 4'(calm_r != 4'hf);
      end
   end

   default clocking tick @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_off_zero; sink_oe_n |-> code_a == 5'h00 && led_channel_b_sink == 5'h00; endproperty
   a_off_zero: assert property (p_off_zero) else $error("code set in shutdown");
   // one step down; the code moves three edges after the line, so
   // the value from before the edge is the one sampled three cycles back.
   property p_step; $fell(enable_dim_line) && enabled && calm_r == 4'hf
      |-> ##4 code_a == $past(code_a, 3) - 5'h01 && led_channel_b_sink == code_a; endproperty
   a_step: assert property (p_step) else $error("bad step on falling edge");
   property p_en_zero; $rose(enabled) |-> code_a == 5'h00; endproperty
   a_en_zero: assert property (p_en_zero) else $error("current on at enable");
   property p_off_early; $rose(sink_oe_n) |-> low_cnt_r >= OFF_COUNT; endproperty
   a_off_early: assert property (p_off_early) else $error("shutdown too early");
   property p_off_due; low_cnt_r == OFF_COUNT + 6 |-> sink_oe_n && !enabled; endproperty
   a_off_due: assert property (p_off_due) else $error("shutdown missing");
   property p_pump_early; $changed(pump_output) && pump_output == PUMP_1P5
      |-> fail_cnt_r >= PUMP_COUNT; endproperty
   a_pump_early: assert property (p_pump_early) else $error("pump raised early");
   property p_pump_due; fail_cnt_r == PUMP_COUNT + 6 |-> pump_output == PUMP_1P5; endproperty
   a_pump_due: assert property (p_pump_due) else $error("pump not raised");
   property p_prot; (uv_low || over_temp) [*4] |-> code_a == 5'h00; endproperty
   a_prot: assert property (p_prot) else $error("current on under protection");
   property p_pump_start; $rose(enabled) |-> pump_output == PUMP_1X; endproperty
   a_pump_start: assert property (p_pump_start) else $error("pump not 1x");

   c_wrap: cover property ($fell(enable_dim_line) && enabled && code_a == 5'h00);
   c_off: cover property ($rose(sink_oe_n));
   c_pump: cover property ($rose(pump_output == PUMP_1P5));
endmodule : dimmer_monitor

/* dimmer_pkg.sv */
// Types shared by both ends of the dimming link.
// Assumes dimmer_cfg.svh supplies the numeric settings.
package dimmer_pkg;
   // Pump modes.
   typedef enum logic [1:0] {
      PUMP_1X  = 2'h1,
      PUMP_1P5 = 2'h2
   } pump_mode_type;

   // Device states.
   typedef enum logic [2:0] {
      DEV_SHUTDOWN = 3'h1,
      DEV_ENABLED  = 3'h2,
      DEV_DIMMING  = 3'h4
   } dev_state_type;

   // Host states.
   typedef enum logic [3:0] {
      HOST_IDLE  = 4'h1,
      HOST_SETUP = 4'h2,
      HOST_HIGH  = 4'h4,
      HOST_LOW   = 4'h8
   } host_state_type;

   // Five-bit current code.
   typedef logic [4:0] code_type;
endpackage : dimmer_pkg

/* dimmer_timer.sv */
// Up counter that raises done once run has been held for COUNT cycles.
// Assumes the caller holds run high while timing and low to restart.
`timescale 1ns/10ps
module dimmer_timer #(
   parameter int unsigned COUNT = 16
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic run,
   output logic      done
);
   logic [23:0] cnt_r;  // Cycles elapsed.
   logic [23:0] cnt_nxt;
   logic        done_nxt;

   // Count while running; clearing on a dropped run restarts the interval.
   always_comb begin
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      if (!run) begin
         cnt_nxt = 24'h000000;
      end else if (cnt_r >= 24'(COUNT - 1)) begin
         done_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + 24'h000001;
      end
   end

   // Register the count and the done flag.
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 24'h000000;
         done  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         done  <= done_nxt;
      end
   end
endmodule : dimmer_timer

/* testbench.sv */
// Self-checking bench: host and device joined by the dimming link.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/10ps
module testbench;
   import dimmer_pkg::*;
   localparam int OFF_N  = 50; // Short shutdown time keeps the run brief.
   localparam int PUMP_N = 20; // Short pump delay, same reason.
   typedef struct packed {logic fresh; logic [5:0] n; code_type code;} row_type;
   // Fresh rows start from shutdown; others add pulses to the count.
   row_type rows [8] = '{'{1'b1, 6'h01, 5'h1f}, '{1'b0, 6'h03, 5'h1c},
      '{1'b1, 6'h1f, 5'h01}, '{1'b0, 6'h01, 5'h00}, '{1'b0, 6'h01, 5'h1f},
      '{1'b1, 6'h20, 5'h00}, '{1'b1, 6'h21, 5'h1f}, '{1'b1, 6'h3f, 5'h01}};
   logic          clock = 1'b0;
   logic          sys_rst = 1'b1;
   logic          start = 1'b0;
   logic          shutdown = 1'b0;
   logic          uv_low = 1'b0;
   logic          over_temp = 1'b0;
   logic          reg_fail = 1'b0;
   logic [5:0]    pulses = 6'h00;
   logic          busy, sink_oe_n, enabled;
   code_type      code_a, code_b;
   pump_mode_type pump;
   int            fail_count = 0;
   int            samples_checked = 0;
   int            cycles = 0;

   dimmer_link_if dimmer_link_if_i ();
   dimmer_host dimmer_host_i (.clock, .sys_rst, .start, .pulses, .shutdown, .busy,
      .link(dimmer_link_if_i));
   dimmer_device #(.OFF_COUNT(OFF_N), .PUMP_COUNT(PUMP_N)) dimmer_device_i (.clock,
      .sys_rst, .link(dimmer_link_if_i), .uv_low, .over_temp, .reg_fail,
      .led_channel_a_sink(code_a), .led_channel_b_sink(code_b), .sink_oe_n,
      .pump_output(pump), .enabled);
   dimmer_monitor #(.OFF_COUNT(OFF_N), .PUMP_COUNT(PUMP_N)) dimmer_monitor_i (.clock,
      .sys_rst, .enable_dim_line(dimmer_link_if_i.enable_dim_line), .uv_low, .over_temp,
      .reg_fail, .led_channel_a_sink(code_a), .led_channel_b_sink(code_b), .sink_oe_n,
      .pump_output(pump), .enabled);

   // Clock, and a ceiling well above the expected 9000 or so cycles.
   always #25 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         give_verdict();
      end
   end

   // Waits n edges, then steps off the edge before inputs change.
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : step

   task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Asks the host for n pulses and waits out the train and device lag.
   task automatic send(input logic [5:0] n);
      pulses = n;
      start = 1'b1;
      step(1);
      start = 1'b0;
      step(2);
      for (int i = 0; i < 5000 && busy; i++) step(1);
      step(4);
      // A train that never ends counts as a mismatch here.
      check("busy", {4'h0, busy}, 5'h00);
   endtask : send

   // Holds the line low past the shutdown time.
   task automatic power_off;
      shutdown = 1'b1;
      step(OFF_N + 20);
      check("oe_n", {4'h0, sink_oe_n}, 5'h01);
      check("code_a", code_a, 5'h00);
      shutdown = 1'b0;
   endtask : power_off

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   initial begin
      step(5);
      check("pump", {3'h0, pump}, {3'h0, PUMP_1X});
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         if (rows[i].fresh) power_off();
         send(rows[i].n);
         check("code_a", code_a, rows[i].code);
         check("code_b", code_b, rows[i].code);
      end
      // Undervoltage, then over-temperature; the count must survive.
      for (int k = 0; k < 2; k++) begin
         {uv_low, over_temp} = (k == 0) ? 2'b10 : 2'b01;
         step(6);
         check("code_a", code_a, 5'h00);
         {uv_low, over_temp} = 2'b00;
         step(6);
         check("code_a", code_a, 5'h01);
      end
      reg_fail = 1'b1;
      step(PUMP_N - 4);
      check("pump", {3'h0, pump}, {3'h0, PUMP_1X});
      step(12);
      check("pump", {3'h0, pump}, {3'h0, PUMP_1P5});
      reg_fail = 1'b0;
      power_off();
      send(6'h01);
      check("pump", {3'h0, pump}, {3'h0, PUMP_1X});
      // Reset in mid-run, then a fresh two-pulse train.
      sys_rst = 1'b1;
      step(2);
      check("enabled", {4'h0, enabled}, 5'h00);
      sys_rst = 1'b0;
      send(6'h02);
      check("code_a", code_a, 5'h1e);
      give_verdict();
   end
endmodule : testbench
